/* File: rtl/ocg_defines.vh */
// Offsets, field positions, reset values and timing constants for the clock-gate block
`ifndef OCG_DEFINES_VH
`define OCG_DEFINES_VH
`define OCG_ADDR_W 20
`define OCG_GATE_A_ADDR 20'hf00f0
`define OCG_SETTLE_SEL_ADDR 20'hfffa3
`define OCG_STATUS_ADDR 20'hfffa2
`define OCG_GATE_A_RST 8'h00
`define OCG_SETTLE_SEL_RST 3'h7
`define OCG_STATUS_RST 8'h00
`define OCG_GATE_A_MASK 8'hfd
`define OCG_SETTLE_PAD 16
`define OCG_CNT_W 19
`define OCG_BIT_ITIMER 7
`define OCG_BIT_CMP 6
`define OCG_BIT_ADC 5
`define OCG_BIT_TWS 4
`define OCG_BIT_SERB 3
`define OCG_BIT_SERA 2
`define OCG_BIT_TARR 0
`endif

/* File: rtl/ocg_osc_settle_gate.v */
// Oscillator settle timer, settle status register and peripheral clock gates
`include "ocg_defines.vh"

//
// How it works
// - Clearing the main oscillator halt starts an automatic settle wait.
// - Settle time select resets to 07H.
// - Code k selects (2^k+16) crystal cycles, k = 8,9,10,11,13,15,17,18.
// - Settle counter stops at the selected time.
// - After stop release, status shows bits only up to selected time.
// - Counting begins at real oscillation, not at circuit start.
// - Gate register clears to 00H, peripherals unclocked and in reset.
// - Gate register takes single-bit and whole-byte writes.
// - Gate bits 7..2 and 0 enable seven units; bit 1 reads zero.
// - Interval timer gate low stops clock, blocks writes, holds reset.
// - Comparator gate low stops clock, blocks writes, holds reset.
// - Status clears on reset, stop entry, halt set; fills with ones.
module ocg_osc_settle_gate #(
   parameter SETTLE_PAD = `OCG_SETTLE_PAD
) (
   input wire I_MCLK,
   input wire I_RESETN,
   input wire [19:0] I_ADDR,
   input wire I_WR,
   input wire I_RD,
   input wire I_BIT_OP,
   input wire [2:0] I_BIT_SEL,
   input wire [7:0] I_WDATA,
   output reg [7:0] O_RDATA,
   input wire I_MAIN_OSC_HALT,
   input wire I_STOP_ENTER,
   input wire I_STOP_RELEASE,
   input wire I_OSC_RUNNING,
   input wire I_XTAL_CLK,
   output wire O_SETTLE_DONE,
   output wire [7:0] O_PERIPH_CLK_EN,
   output wire [7:0] O_PERIPH_RESET_N,
   output wire [7:0] O_PERIPH_WR_EN
);

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Crystal cycles for each select code
   function [18:0] settle_limit;
      input [2:0] code;
      reg [4:0] k;
      begin
         case (code)
            3'h0: k = 5'h08;
            3'h1: k = 5'h09;
            3'h2: k = 5'h0a;
            3'h3: k = 5'h0b;
            3'h4: k = 5'h0d;
            3'h5: k = 5'h0f;
            3'h6: k = 5'h11;
            default: k = 5'h12;
         endcase
         settle_limit = (19'h00001 << k) + SETTLE_PAD[18:0];
      end
   endfunction

   //------------------------------------------------------------
   // Pin synchronisers (three stages, second and third agree)
   //------------------------------------------------------------
   // Crystal clock is sampled as data; it must run below an eighth of I_MCLK
   reg [3:0] s1_reg;
   reg [3:0] s2_reg;
   reg [3:0] s3_reg;
   reg [3:0] clean_reg;
   wire [3:0] pins = {I_XTAL_CLK, I_OSC_RUNNING, I_STOP_RELEASE, I_STOP_ENTER};

   always @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
         s3_reg <= 4'h0;
         clean_reg <= 4'h0;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         clean_reg <= (s2_reg & s3_reg) | (clean_reg & (s2_reg | s3_reg));
      end
   end
   wire stop_enter = clean_reg[0];
   wire stop_release = clean_reg[1];
   wire osc_running = clean_reg[2];
   wire xtal_clk = clean_reg[3];


   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   reg [2:0] settle_sel_reg;
   reg [7:0] gate_a_reg;
   wire wr_sel = I_WR && (I_ADDR == `OCG_SETTLE_SEL_ADDR);
   wire wr_gate = I_WR && (I_ADDR == `OCG_GATE_A_ADDR);
   wire [7:0] bit_mask = 8'h01 << I_BIT_SEL;
   reg [7:0] gate_a_next;

   // Fixed-zero gate bit is masked after every write
   always @* begin
      gate_a_next = gate_a_reg;
      if (wr_gate) begin
         if (I_BIT_OP)
            gate_a_next = (gate_a_reg & ~bit_mask) | (I_WDATA & bit_mask);
         else
            gate_a_next = I_WDATA;
      end
      gate_a_next = gate_a_next & `OCG_GATE_A_MASK;
   end

   // Bit writes to the select register are dropped; only byte writes land
   always @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         settle_sel_reg <= `OCG_SETTLE_SEL_RST;
         gate_a_reg <= `OCG_GATE_A_RST;
      end else begin
         if (wr_sel && !I_BIT_OP)
            settle_sel_reg <= I_WDATA[2:0];
         gate_a_reg <= gate_a_next;
      end
   end

   //------------------------------------------------------------
   // Settle counter and status
   //------------------------------------------------------------
   // Event edges are taken against last cycle's level
   reg halt_d_reg;
   reg stop_d_reg;
   reg rel_d_reg;
   reg xclk_d_reg;
   reg armed_reg;
   reg [18:0] cnt_reg;
   reg [7:0] status_reg;
   wire [18:0] limit = settle_limit(settle_sel_reg);
   wire start_ev = (halt_d_reg && !I_MAIN_OSC_HALT) || (stop_release && !rel_d_reg);
   wire clear_ev = I_MAIN_OSC_HALT || (stop_enter && !stop_d_reg);
   wire xtal_tick = xtal_clk && !xclk_d_reg;
   integer i;
   reg [7:0] status_next;

   // Status bit 7 tracks the shortest time, bit 0 the longest
   always @* begin
      status_next = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
         if (cnt_reg >= settle_limit(i[2:0]) && i[2:0] <= settle_sel_reg)
            status_next[7 - i] = 1'b1;
      end
   end

   // Clear wins over start when both fall in one cycle
   // Counting only on crystal edges seen while the oscillator runs
   always @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         halt_d_reg <= 1'b1;
         stop_d_reg <= 1'b0;
         rel_d_reg <= 1'b0;
         xclk_d_reg <= 1'b0;
         armed_reg <= 1'b0;
         cnt_reg <= 19'h00000;
         status_reg <= `OCG_STATUS_RST;
      end else begin
         halt_d_reg <= I_MAIN_OSC_HALT;
         stop_d_reg <= stop_enter;
         rel_d_reg <= stop_release;
         xclk_d_reg <= xtal_clk;
         if (clear_ev) begin
            armed_reg <= 1'b0;
            cnt_reg <= 19'h00000;
            status_reg <= 8'h00;
         end else begin
            if (start_ev) begin
               armed_reg <= 1'b1;
               cnt_reg <= 19'h00000;
            end else if (armed_reg && osc_running && xtal_tick && cnt_reg < limit)
               cnt_reg <= cnt_reg + 19'h00001;
            status_reg <= status_next;
         end
      end
   end

   assign O_SETTLE_DONE = armed_reg && (cnt_reg >= limit);

   //------------------------------------------------------------
   // Gate outputs and read mux
   //------------------------------------------------------------
   // Clock, reset release and write enable follow the same bit
   assign O_PERIPH_CLK_EN = gate_a_reg;
   assign O_PERIPH_RESET_N = gate_a_reg;
   assign O_PERIPH_WR_EN = gate_a_reg;

   // Read data stands one cycle, zero when no read
   reg [7:0] rdata_next;
   always @* begin
      rdata_next = 8'h00;
      if (!I_RD)
         rdata_next = 8'h00;
      else if (I_ADDR == `OCG_SETTLE_SEL_ADDR)
         rdata_next = {5'h00, settle_sel_reg};
      else if (I_ADDR == `OCG_GATE_A_ADDR)
         rdata_next = gate_a_reg;
      else if (I_ADDR == `OCG_STATUS_ADDR)
         rdata_next = status_reg;
      else
         rdata_next = 8'h00;
   end

   always @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN)
         O_RDATA <= 8'h00;
      else
         O_RDATA <= rdata_next;
   end
endmodule

/* File: bench/ocg_checker.sv */
// Port checker for the settle timer and clock gate block
module ocg_checker(input logic I_MCLK, I_RESETN, I_WR, I_RD, I_BIT_OP, I_MAIN_OSC_HALT,
   input logic O_SETTLE_DONE, input logic [19:0] I_ADDR, input logic [7:0] I_WDATA,
   input logic [7:0] O_RDATA, O_PERIPH_CLK_EN);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RESETN);
   sequence s_gate_wr; I_WR && I_ADDR == 20'hf00f0; endsequence
   sequence s_halt_held; I_MAIN_OSC_HALT [*3]; endsequence
   AST_GATE_BIT1: assert property (O_PERIPH_CLK_EN[1] == 1'b0) else $error("gate bit1");
   AST_GATE_HOLD: assert property (!(I_WR && I_ADDR == 20'hf00f0) |=> $stable(O_PERIPH_CLK_EN))
      else $error("gate moved");
   AST_GATE_BYTE: assert property (s_gate_wr and !I_BIT_OP
      |=> O_PERIPH_CLK_EN == ($past(I_WDATA) & 8'hfd)) else $error("gate byte");
   AST_SEL_RD: assert property (I_RD && I_ADDR == 20'hfffa3 |=> O_RDATA[7:3] == 5'h00)
      else $error("select pad");
   AST_GATE_RD: assert property (I_RD && I_ADDR == 20'hf00f0 |=> O_RDATA == $past(O_PERIPH_CLK_EN))
      else $error("gate read");
   AST_RD_IDLE: assert property (!I_RD |=> O_RDATA == 8'h00) else $error("read idle");
   AST_HALT_CLR: assert property (s_halt_held |=> !O_SETTLE_DONE) else $error("halt");
   AST_DONE_CAUSE: assert property ($rose(O_SETTLE_DONE) |-> !$past(I_MAIN_OSC_HALT))
      else $error("done cause");
endmodule

/* File: bench/ocg_xtal_model.sv */
// Crystal model: start-up gap, then a free clock while enabled
module ocg_xtal_model(input logic i_halt, output logic o_run, output logic o_xclk);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_run = 0;
   initial o_xclk = 0;
   always @(negedge i_halt) #2003 o_run = !i_halt;
   always @(posedge i_halt) o_run = 0;
   always #50 o_xclk = o_run ? !o_xclk : 1'b0;
endmodule

/* File: bench/tb_osc_settle_and_periph_clock_gate.sv */
// Testbench for the settle timer and clock gate block
module tb_osc_settle_and_periph_clock_gate;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, rstn = 0, wr = 0, rd = 0, bop = 0, halt = 1, se = 0, sr = 0;
   logic [19:0] addr = 0;
   logic [2:0] bsel = 0;
   logic [7:0] wd = 0, rdata, cen, rsn, wen;
   wire run, xclk, done;
   int n_errors = 0, n_checks = 0, c;
   always #5 mclk = ~mclk;
   ocg_osc_settle_gate i_dut(.I_MCLK(mclk), .I_RESETN(rstn), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
      .I_BIT_OP(bop), .I_BIT_SEL(bsel), .I_WDATA(wd), .O_RDATA(rdata), .I_MAIN_OSC_HALT(halt),
      .I_STOP_ENTER(se), .I_STOP_RELEASE(sr), .I_OSC_RUNNING(run), .I_XTAL_CLK(xclk),
      .O_SETTLE_DONE(done), .O_PERIPH_CLK_EN(cen), .O_PERIPH_RESET_N(rsn), .O_PERIPH_WR_EN(wen));
   ocg_xtal_model i_xtal(.i_halt(halt), .o_run(run), .o_xclk(xclk));
   task report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("Error %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wrt(input logic [19:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
      @(negedge mclk);
      {addr, wd, bop, bsel, wr} = {a, d, b, s, 1'b1};
      @(negedge mclk);
      wr = 0;
   endtask
   task rdc(input logic [19:0] a, input logic [7:0] e);
      @(negedge mclk);
      {addr, rd} = {a, 1'b1};
      @(negedge mclk);
      rd = 0;
      chk(rdata, e);
   endtask
   task wdone(input int lim);
      c = 0;
      while (done !== 1'b1 && c < lim) begin
         @(negedge mclk);
         c++;
      end
      if (c >= lim) begin
         n_errors++;
         report_and_stop;
      end
   endtask
   task t_gate;
      rdc(20'hf00f0, 8'h00);
      rdc(20'hfffa3, 8'h07);
      wrt(20'hf00f0, 8'hff, 0, 0);
      rdc(20'hf00f0, 8'hfd);
      chk(wen & rsn, 8'hfd);
      wrt(20'hf00f0, 8'h00, 1, 7);
      chk(wen, 8'h7d);
      wrt(20'hf00f0, 8'h00, 1, 6);
      chk(rsn, 8'h3d);
      wrt(20'hf00f0, 8'h02, 1, 1);
      rdc(20'hf00f0, 8'h3d);
      rdc(20'h00123, 8'h00);
   endtask
   task t_sel;
      wrt(20'hfffa3, 8'hf8, 0, 0);
      rdc(20'hfffa3, 8'h00);
      wrt(20'hfffa3, 8'h01, 1, 0);
      rdc(20'hfffa3, 8'h00);
   endtask
   task t_settle;
      halt = 0;
      wdone(4000);
      chk((c > 2905 && c < 2940) ? 8'h01 : 8'h00, 8'h01);
      rdc(20'hfffa2, 8'h80);
      repeat (3000) @(negedge mclk);
      rdc(20'hfffa2, 8'h80);
      se = 1;
      repeat (8) @(negedge mclk);
      rdc(20'hfffa2, 8'h00);
      {se, sr} = 2'b01;
      wdone(3000);
      rdc(20'hfffa2, 8'h80);
      halt = 1;
      repeat (6) @(negedge mclk);
      rdc(20'hfffa2, 8'h00);
   endtask
   initial begin
      repeat (20) @(negedge mclk);
      rstn = 1;
      t_gate;
      t_sel;
      t_settle;
      report_and_stop;
   end
endmodule
bind ocg_osc_settle_gate ocg_checker i_chk(.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_WR(I_WR),
   .I_RD(I_RD), .I_BIT_OP(I_BIT_OP), .I_MAIN_OSC_HALT(I_MAIN_OSC_HALT), .I_ADDR(I_ADDR),
   .O_SETTLE_DONE(O_SETTLE_DONE), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
   .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN));
